// ---- design/eeprom_identification_page_access.sv ----
// Purpose: I2C target logic for reading and lock-querying the identification page.
// Assumes: The controller drives the serial clock; no clock stretching is done.
// Notes:   Main array writes are not part of this block; array reads return erased data.
// Behaviour
// - Acknowledge write select and page address bytes.
// - Low six address bits give page offset.
// - Acknowledge read select, output bytes from offset.
// - Lock query: acknowledge select and address bytes.
// - Lock query expects one data byte.
// - Unlocked page acknowledges the query byte.
// - Locked page answers query with no-ack.
// - Start after query byte resets logic.
// - Stop after that start returns standby.
// - Page ships locked, always answer no-ack.
// - Delivered array bytes read as FFh.
// - Page locked; serial first sixteen, rest FFh.
// - Page access loads shared address counter.
// - Missing ack stops output until start or stop.
// - Address counter advances after each byte read.
// - Writes to the page are refused.
`timescale 1ns/1ps
module eeprom_identification_page_access #(
  parameter logic [6:0]   ARRAY_SEL  = 7'h50,  // Select code of the main array.
  parameter logic [6:0]   IDPAGE_SEL = 7'h58,  // Select code of the identification page.
  parameter logic [127:0] SERIAL     = 128'h0123456789abcdef0123456789abcdef // Arbitrary serial value.
) (
  input  wire logic CLOCK,     // Core clock, 20 MHz.
  input  wire logic RSTN,      // Asynchronous reset, active low.
  input  wire logic CE,        // Clock enable.
  input  wire logic SCL_I,     // Serial clock pin.
  input  wire logic SDA_I,     // Serial data pin level.
  output logic      SDA_O,     // Serial data output level, always low when driven.
  output logic      SDA_OE,    // High while the block pulls data low.
  output logic      BUSY       // High from any start until the following stop, selected or not.
);
  // ****************************************
  // Bus condition detection
  // ****************************************
  logic scl;        // Synchronised clock.
  logic sda;        // Synchronised data.
  logic scl_rise;   // Clock rising edge.
  logic scl_fall;   // Clock falling edge.
  logic start_det;  // Start condition.
  logic stop_det;   // Stop condition.

  bus_cond_detect u_cond (
    .clk       (CLOCK),
    .rst_n     (RSTN),
    .ce        (CE),
    .scl_pin   (SCL_I),
    .sda_pin   (SDA_I),
    .scl       (scl),
    .sda       (sda),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .start_det (start_det),
    .stop_det  (stop_det)
  );

  // ****************************************
  // Types and state
  // ****************************************
  typedef enum logic [2:0] {
    IDLE,      // Waiting for a start.
    SELECT,    // Receiving the device select byte.
    ADDR_HI,   // Receiving the high address byte.
    ADDR_LO,   // Receiving the low address byte.
    WDATA,     // Receiving the lock query data byte.
    RDATA,     // Sending a data byte.
    IGNORE     // Waiting for start or stop.
  } phase_t;

  typedef struct packed {
    phase_t                                      phase;      // Protocol phase.
    logic                                        in_ack;     // In the ninth bit of a byte.
    logic                                        ack_drive;  // Drive an acknowledge in the ninth bit.
    logic [3:0]                                  bit_cnt;    // Bit within byte.
    logic [7:0]                                  shreg;      // Receive or transmit shift register.
    logic                                        id_sel;     // Current transfer targets the page.
    logic                                        page_target; // Address phase addressed the page.
    logic [identification_page_pkg::ARRAY_ADDR_BITS-1:0]     addr;       // Shared internal address counter.
    logic                                        locked;     // Page lock state.
    logic                                        sda_oe;     // Data output enable.
    logic                                        busy;       // Busy flag, set from a start to the next stop.
  } core_state_t;

  core_state_t st_reg;   // Registered state.
  core_state_t st_next;  // Next state.

  // ****************************************
  // Functions
  // ****************************************
  // Returns the byte of the identification page at an offset.
  function automatic logic [7:0] page_byte(input logic [identification_page_pkg::OFFSET_BITS-1:0] off);
    logic [7:0] b;
    b = identification_page_pkg::ERASED_BYTE;
    if (off < 6'(identification_page_pkg::SERIAL_BYTES)) begin
      b = SERIAL[127 - 8*off[3:0] -: 8];
    end
    return b;
  endfunction

  // Returns the byte to transmit for the current target and address.
  function automatic logic [7:0] read_byte(input logic id, input logic [identification_page_pkg::ARRAY_ADDR_BITS-1:0] a);
    logic [7:0] b;
    b = identification_page_pkg::ERASED_BYTE;
    if (id) begin
      b = page_byte(a[identification_page_pkg::OFFSET_BITS-1:0]);
    end
    return b;
  endfunction

  // ****************************************
  // Protocol engine
  // ****************************************
  // Bits are taken on the rising clock edge; the data line changes on the falling edge.
  always_comb begin
    logic [7:0] rx;
    rx = {st_reg.shreg[6:0], sda};
    st_next = st_reg;
    st_next.busy = (st_reg.phase != IDLE);
    if (start_det) begin
      // A start, repeated or not, resets the byte engine and drops any truncated command.
      st_next.phase   = SELECT;
      st_next.bit_cnt = identification_page_pkg::BIT_RESET;
      st_next.in_ack  = 1'b0;
      st_next.sda_oe  = 1'b0;
    end else if (stop_det) begin
      // A stop always returns to standby.
      st_next.phase  = IDLE;
      st_next.in_ack = 1'b0;
      st_next.sda_oe = 1'b0;
    end else if (st_reg.phase == IDLE || st_reg.phase == IGNORE) begin
      st_next.sda_oe = 1'b0;
    end else if (scl_rise && st_reg.in_ack) begin
      // Ninth bit: a read byte checks the controller's acknowledge.
      if (st_reg.phase == RDATA && sda) begin
        st_next.phase = IGNORE;
      end
    end else if (scl_rise) begin
      // A byte being sent keeps its shift register; only the falling edge moves it.
      st_next.shreg   = (st_reg.phase == RDATA) ? st_reg.shreg : rx;
      st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
    end else if (scl_fall && st_reg.in_ack) begin
      // End of the ninth bit: release the line or load the next byte to send.
      st_next.in_ack  = 1'b0;
      st_next.bit_cnt = identification_page_pkg::BIT_RESET;
      st_next.sda_oe  = 1'b0;
      if (st_reg.phase == RDATA) begin
        st_next.shreg  = read_byte(st_reg.id_sel, st_reg.addr);
        st_next.sda_oe = ~st_next.shreg[7];
        st_next.addr   = st_reg.addr + 14'h0001;
      end else if (!st_reg.ack_drive) begin
        st_next.phase = IGNORE;
      end
    end else if (scl_fall && st_reg.bit_cnt == identification_page_pkg::BIT_LAST + 4'h1) begin
      // Eight bits done: decide the ninth bit.
      st_next.in_ack    = 1'b1;
      st_next.ack_drive = 1'b0;
      unique case (st_reg.phase)
        SELECT: begin
          if (st_reg.shreg[7:1] == IDPAGE_SEL || st_reg.shreg[7:1] == ARRAY_SEL) begin
            st_next.ack_drive = 1'b1;
            st_next.id_sel    = (st_reg.shreg[7:1] == IDPAGE_SEL);
            st_next.phase     = st_reg.shreg[0] ? RDATA : ADDR_HI;
            if (!st_reg.shreg[0]) begin
              st_next.page_target = (st_reg.shreg[7:1] == IDPAGE_SEL);
            end
          end
        end
        ADDR_HI: begin
          st_next.ack_drive = 1'b1;
          st_next.addr      = {st_reg.shreg[5:0], st_reg.addr[7:0]};
          st_next.phase     = ADDR_LO;
        end
        ADDR_LO: begin
          st_next.ack_drive = 1'b1;
          if (st_reg.page_target) begin
            st_next.addr = {8'h00, st_reg.shreg[5:0]};
          end else begin
            st_next.addr = {st_reg.addr[13:8], st_reg.shreg};
          end
          st_next.phase = WDATA;
        end
        WDATA: begin
          // Lock query byte: acknowledge only if the page is unlocked; the page never accepts data.
          st_next.ack_drive = st_reg.page_target ? ~st_reg.locked : 1'b0;
          st_next.phase     = IGNORE;
        end
        RDATA: begin
          st_next.ack_drive = 1'b0;
        end
        default: begin
          st_next.ack_drive = 1'b0;
        end
      endcase
      st_next.sda_oe = st_next.ack_drive;
      if (st_reg.phase == RDATA) begin
        st_next.sda_oe = 1'b0;
      end
    end else if (scl_fall && st_reg.phase == RDATA && st_reg.bit_cnt != identification_page_pkg::BIT_RESET) begin
      // Shift out the next bit of the byte being sent.
      st_next.shreg  = {st_reg.shreg[6:0], 1'b1};
      st_next.sda_oe = ~st_reg.shreg[6];
    end else if (scl_fall && st_reg.phase == RDATA && !st_reg.sda_oe && st_reg.bit_cnt == identification_page_pkg::BIT_RESET
                 && st_reg.shreg == 8'h00) begin
      st_next.sda_oe = 1'b0;
    end
    // An acknowledged ninth bit in the ignore phase releases the data line on the falling edge.
    if (!start_det && !stop_det && scl_fall && st_reg.in_ack && st_reg.phase == IGNORE && st_reg.ack_drive) begin
      st_next.sda_oe = 1'b0;
    end
  end

  // Register the state under the clock enable.
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      st_reg <= '{phase: IDLE, in_ack: 1'b0, ack_drive: 1'b0, bit_cnt: identification_page_pkg::BIT_RESET,
                  shreg: 8'h00, id_sel: 1'b0, page_target: 1'b0, addr: identification_page_pkg::ADDR_RESET,
                  locked: identification_page_pkg::PAGE_LOCKED_RESET, sda_oe: 1'b0, busy: 1'b0};
    end else if (CE) begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // The data pin is open drain: it is only ever pulled low.
  assign SDA_O  = 1'b0;
  assign SDA_OE = st_reg.sda_oe;
  assign BUSY   = st_reg.busy;
endmodule

// ---- design/identification_page_pkg.sv ----
// Purpose: Shared constants for the identification page I2C target.
// Assumes: 20 MHz core clock, serial clock and data sampled as plain inputs.
// Notes:   Device select encodings are parameters of the top module.
package identification_page_pkg;
  // Byte and page geometry.
  localparam int unsigned PAGE_BYTES      = 64;   // Identification page size in bytes.
  localparam int unsigned OFFSET_BITS     = 6;    // Width of identification_page_byte_offset.
  localparam int unsigned SERIAL_BYTES    = 16;   // Bytes of unique_serial_number.
  localparam int unsigned ARRAY_ADDR_BITS = 14;   // Shared address counter width.
  // Values after reset or delivery.
  localparam logic [7:0]  ERASED_BYTE     = 8'hff; // Content of an unprogrammed byte.
  localparam logic [ARRAY_ADDR_BITS-1:0] ADDR_RESET = 14'h0000; // Address counter reset value.
  localparam logic        PAGE_LOCKED_RESET = 1'b1; // The page leaves the factory locked.
  // Bit counter values.
  localparam logic [3:0]  BIT_LAST        = 4'h7; // Index of the eighth bit of a byte.
  localparam logic [3:0]  BIT_RESET       = 4'h0; // Bit counter after reset.
endpackage

// ---- design/bus_cond_detect.sv ----
// Purpose: Synchronises serial clock and data and finds edges, start and stop.
// Assumes: Pins are asynchronous to CLOCK and settle well within a clock period.
// Notes:   The first synchroniser stage is read only by the second stage.
`timescale 1ns/1ps
module bus_cond_detect (
  input  wire logic clk,        // Core clock.
  input  wire logic rst_n,      // Asynchronous reset, active low.
  input  wire logic ce,         // Clock enable, freezes state when low.
  input  wire logic scl_pin,    // Serial clock pin level.
  input  wire logic sda_pin,    // Serial data pin level.
  output logic      scl,        // Synchronised serial clock.
  output logic      sda,        // Synchronised serial data.
  output logic      scl_rise,   // Pulse on a rising serial clock edge.
  output logic      scl_fall,   // Pulse on a falling serial clock edge.
  output logic      start_det,  // Pulse on a start or repeated start.
  output logic      stop_det    // Pulse on a stop condition.
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [1:0] scl_sync;  // Two-stage serial clock synchroniser.
    logic [1:0] sda_sync;  // Two-stage serial data synchroniser.
    logic       scl_d;     // Delayed synchronised clock.
    logic       sda_d;     // Delayed synchronised data.
  } sync_state_t;

  sync_state_t st_reg;   // Registered state.
  sync_state_t st_next;  // Next state.

  // Shift the pins through the synchronisers and keep one delayed copy.
  always_comb begin
    st_next = st_reg;
    st_next.scl_sync = {st_reg.scl_sync[0], scl_pin};
    st_next.sda_sync = {st_reg.sda_sync[0], sda_pin};
    st_next.scl_d    = st_reg.scl_sync[1];
    st_next.sda_d    = st_reg.sda_sync[1];
  end

  // Register the state; the bus idles high.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '1;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // Decode edges and conditions from the second stage and its delayed copy.
  assign scl       = st_reg.scl_sync[1];
  assign sda       = st_reg.sda_sync[1];
  assign scl_rise  = ce & scl & ~st_reg.scl_d;
  assign scl_fall  = ce & ~scl & st_reg.scl_d;
  assign start_det = ce & scl & st_reg.scl_d & ~sda & st_reg.sda_d;
  assign stop_det  = ce & scl & st_reg.scl_d & sda & ~st_reg.sda_d;
endmodule

// ---- tb/identification_page_monitor.sv ----
// Purpose: Pin-level checker of the identification page target.
// Assumes: Serial clock of eight core clocks, low five and high three.
// Notes:   Attached by bind to the top module.
`timescale 1ns/1ps
module identification_page_monitor (
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic CE,
  input wire logic SCL_I,
  input wire logic SDA_I,
  input wire logic SDA_O,
  input wire logic SDA_OE,
  input wire logic BUSY
);
  // ****************
  // Pin history
  // ****************
  logic       scl_reg;   // Serial clock one cycle back.
  logic       sda_reg;   // Serial data one cycle back.
  logic       seen_reg;  // A start was seen since reset.
  logic [6:0] since_reg; // Cycles since the last start, saturating.
  logic       start_w;   // Start condition on the pins.
  logic       stop_w;    // Stop condition on the pins.
  assign start_w = SCL_I && scl_reg && sda_reg && !SDA_I;
  assign stop_w  = SCL_I && scl_reg && !sda_reg && SDA_I;
  // Tracks the pins and the time since the last start.
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      scl_reg   <= 1'b1;
      sda_reg   <= 1'b1;
      seen_reg  <= 1'b0;
      since_reg <= 7'h7f;
    end else begin
      scl_reg   <= SCL_I;
      sda_reg   <= SDA_I;
      seen_reg  <= seen_reg || start_w;
      since_reg <= start_w ? 7'h00 : since_reg + {6'h00, since_reg != 7'h7f};
    end
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  reset_quiet_a: assert property (disable iff (1'b0) !RSTN |-> !SDA_OE && !BUSY)
    else $error("Outputs active in reset");
  drive_low_a: assert property (SDA_OE |-> !SDA_O)
    else $error("Data driven high");
  drive_busy_a: assert property (SDA_OE |-> BUSY)
    else $error("Data driven while idle");
  edge_safe_a: assert property ($changed(SDA_OE) |-> !$past(SCL_I, 2))
    else $error("Data changed in clock high");
  bit_stands_a: assert property ($rose(SDA_OE) |-> SDA_OE[*6])
    else $error("Driven bit too short");
  quiet_select_a: assert property (since_reg < 7'd60 |-> !SDA_OE)
    else $error("Driven during select byte");
  stop_idle_a: assert property (stop_w |-> ##[1:6] !BUSY)
    else $error("No standby after stop");
  busy_cause_a: assert property (BUSY |-> seen_reg)
    else $error("Busy without start");
  cover property (start_w && BUSY);
  cover property ($rose(SDA_OE));
  cover property (stop_w && BUSY);
endmodule
bind eeprom_identification_page_access identification_page_monitor i_identification_page_monitor (.CLOCK(CLOCK), .RSTN(RSTN), .CE(CE),
  .SCL_I(SCL_I), .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE(SDA_OE), .BUSY(BUSY));

// ---- tb/i2c_ctrl_model.sv ----
// Purpose: Bus controller model driving serial clock and data.
// Assumes: 400 ns serial clock period built from eight core clocks.
// Notes:   Data is open drain; the clock stands high between frames.
`timescale 1ns/1ps
module i2c_ctrl_model (
  input  wire logic clk,    // Core clock; steps land on its falling edge.
  input  wire logic sda_w,  // Resolved data wire.
  output logic      scl,    // Serial clock.
  output logic      sda_oe  // High while the controller pulls data low.
);
  // ****************
  // Bus cycles
  // ****************
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  // Waits a number of core clocks.
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  // One bit: data set while low, sampled late in the high phase.
  task automatic bit_x(input logic b, output logic s);
    sda_oe = !b;
    w(3);
    scl = 1'b1;
    w(2);
    s = sda_w;
    w(1);
    scl = 1'b0;
    w(2);
  endtask
  // Start or repeated start: data falls while the clock is high.
  task automatic start();
    sda_oe = 1'b0;
    w(3);
    scl = 1'b1;
    w(2);
    sda_oe = 1'b1;
    w(2);
    scl = 1'b0;
    w(2);
  endtask
  // Stop: data rises while the clock is high.
  task automatic stop();
    sda_oe = 1'b1;
    w(3);
    scl = 1'b1;
    w(2);
    sda_oe = 1'b0;
    w(4);
  endtask
  // Sends a byte and returns the acknowledge of the target.
  task automatic wr(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(v[i], s);
    bit_x(1'b1, s);
    ack = !s;
  endtask
  // Reads a byte, then acknowledges it or leaves it unacknowledged.
  task automatic rd(input logic ack_it, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, v[i]);
    bit_x(!ack_it, s);
  endtask
endmodule

// ---- tb/tb_top.sv ----
// Purpose: Self-checking bench of the identification page target.
// Assumes: 50 ns core clock, serial traffic from the controller model.
// Notes:   Enable is held high throughout.
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin miscompares++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
  // ****************
  // Bench and scenarios
  // ****************
  localparam logic [127:0] SER = 128'h00112233445566778899aabbccddeeff; // Arbitrary serial.
  logic       clock;  // Core clock.
  logic       rstn;   // Reset, active low.
  logic       ce;     // Clock enable.
  logic       scl;    // Serial clock from the controller.
  logic       c_oe;   // Controller pulls data low.
  logic       sda_o;  // Target data level.
  logic       d_oe;   // Target pulls data low.
  logic       busy;   // Target busy, from a start to the next stop.
  logic       ack;    // Last acknowledge seen.
  logic [7:0] d;      // Last byte read.
  int         miscompares;
  int         compares;
  wire logic  sda_w = !((d_oe && !sda_o) || c_oe); // Pull-up when nobody drives.
  eeprom_identification_page_access #(.SERIAL(SER)) i_eeprom_identification_page_access (.CLOCK(clock), .RSTN(rstn),
    .CE(ce), .SCL_I(scl), .SDA_I(sda_w), .SDA_O(sda_o), .SDA_OE(d_oe), .BUSY(busy));
  i2c_ctrl_model i_i2c_ctrl_model (.clk(clock), .sda_w(sda_w), .scl(scl), .sda_oe(c_oe));
  initial begin
    clock = 1'b0;
    forever #25 clock = !clock;
  end
  // Expected page byte: serial first, erased after.
  function automatic logic [7:0] exp_byte(input int k);
    return (k < 16) ? SER[127 - 8 * k -: 8] : 8'hff;
  endfunction
  task automatic summarize();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Waits a bounded time for standby after a stop.
  task automatic wait_idle();
    for (int i = 0; i < 20 && busy !== 1'b0; i++) @(negedge clock);
    `CHK(busy, 1'b0)
    if (busy !== 1'b0) summarize();
  endtask
  task automatic send(input logic [7:0] v, input logic e);
    i_i2c_ctrl_model.wr(v, ack);
    `CHK(ack, e)
  endtask
  // Write select and both address bytes of the page.
  task automatic addr(input logic [7:0] lo);
    i_i2c_ctrl_model.start();
    send(8'hb0, 1'b1);
    send(8'h00, 1'b1);
    send(lo, 1'b1);
  endtask
  task automatic rd_sel();
    i_i2c_ctrl_model.start();
    send(8'hb1, 1'b1);
  endtask
  task automatic sc_seq_read(); // From offset ten to the page end.
    addr(8'hca);
    rd_sel();
    for (int k = 10; k < 64; k++) begin
      i_i2c_ctrl_model.rd(k != 63, d);
      `CHK(d, exp_byte(k))
    end
    i_i2c_ctrl_model.stop();
    wait_idle();
  endtask
  task automatic sc_lock(); // Lock query, then the advised start and stop.
    addr(8'h05);
    send(8'h00, 1'b0);
    i_i2c_ctrl_model.start();
    i_i2c_ctrl_model.stop();
    wait_idle();
    addr(8'h00);
    rd_sel();
    i_i2c_ctrl_model.rd(1'b0, d);
    `CHK(d, exp_byte(0))
    i_i2c_ctrl_model.stop();
    wait_idle();
  endtask
  task automatic sc_cur_nack(); // Array read, then extra clocks after a refusal.
    i_i2c_ctrl_model.start();
    send(8'ha1, 1'b1);
    i_i2c_ctrl_model.rd(1'b0, d);
    `CHK(d, 8'hff)
    i_i2c_ctrl_model.stop();
    wait_idle();
    addr(8'h02);
    rd_sel();
    i_i2c_ctrl_model.rd(1'b0, d);
    `CHK(d, exp_byte(2))
    i_i2c_ctrl_model.rd(1'b1, d);
    `CHK(d, 8'hff)
    i_i2c_ctrl_model.stop();
    wait_idle();
    i_i2c_ctrl_model.start();
    send(8'hc0, 1'b0);
    i_i2c_ctrl_model.stop();
    wait_idle();
  endtask
  initial begin
    miscompares = 0;
    compares = 0;
    rstn = 1'b0;
    ce = 1'b1;
    repeat (10) @(negedge clock);
    rstn = 1'b1;
    repeat (4) @(negedge clock);
    sc_seq_read();
    sc_lock();
    sc_cur_nack();
    summarize();
  end
endmodule
